// ### design/rba_defines.svh
// constants for the rf block access command handler
// assumes inclusion by bare name from the design files
`ifndef RBA_DEFINES_SVH
`define RBA_DEFINES_SVH

// command codes
`define RBA_CMD_RD_SINGLE 8'h20
`define RBA_CMD_WR_SINGLE 8'h21
`define RBA_CMD_RD_MULTI  8'h23

// response flag bytes and error codes
`define RBA_RSP_OK        8'h00
`define RBA_RSP_ERR       8'h01
`define RBA_ERR_UNSPEC    8'h0F
`define RBA_ERR_ABSENT    8'h10
`define RBA_ERR_LOCKED    8'h12
`define RBA_ERR_PROG      8'h13
`define RBA_ERR_RD_PROT   8'h15

// request flag bit positions
`define RBA_FLG_PEXT      3
`define RBA_FLG_ADDR      5
`define RBA_FLG_OPT       6

// sector security status: lock b0, rw b2:1, pw b4:3, b7:5 zero
`define RBA_SSS_MASK      8'h1F

// byte positions inside a request
`define RBA_ARG_BASE      5'h02
`define RBA_ARG_BASE_UID  5'h0A
`define RBA_ARG_BYTES     7

// crc16, reflected polynomial, preset ones
`define RBA_CRC_INIT      16'hFFFF
`define RBA_CRC_POLY      16'h8408

// sector size in blocks, as a power of two (5 bits, 32 blocks)
`define RBA_SECT_BITS     5

// timing
`define RBA_CLK_NS        20
`define RBA_NOM_REPLY_NS  320900
`define RBA_SLOT_NS       302000
`define RBA_SLOTS         18
`define RBA_WIN_CYC ((`RBA_NOM_REPLY_NS + `RBA_SLOTS * `RBA_SLOT_NS + `RBA_CLK_NS - 1) / `RBA_CLK_NS)

`endif

// ### design/rba_pkg.sv
// types for the rf block access command handler
// assumes nothing beyond a compiler with package support
package rba_pkg;

	// command sequencer states
	typedef enum logic [3:0] {
		S_IDLE,
		S_RX,
		S_CHECK,
		S_FETCH,
		S_WAIT_RD,
		S_PROG,
		S_PUSH,
		S_NEXT,
		S_DONE
	} rba_state_t;

endpackage

// ### design/rba_fifo.sv
// shift-register fifo with registered head, valid and ready
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps

module rba_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             i_mclk,
	input  wire logic             i_reset_n,
	// fill side
	input  wire logic             i_wr_valid,
	input  wire logic [WIDTH-1:0] i_wr_data,
	output logic                  o_wr_ready,
	// drain side
	output logic                  o_rd_valid,
	output logic [WIDTH-1:0]      o_rd_data,
	input  wire logic             i_rd_ready
);

	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [CW-1:0]    cnt_q;
	logic [CW-1:0]    cnt_d;
	logic             push;
	logic             pop;

	if (DEPTH < 2) begin : g_bad_depth
		$error("rba_fifo needs a depth of at least two");
	end

	assign push      = i_wr_valid && o_wr_ready;
	assign pop       = o_rd_valid && i_rd_ready;
	assign cnt_d     = cnt_q + CW'(push) - CW'(pop);
	assign o_rd_data = mem_q[0];

	////////////////////////////////////////////////////////////////
	// storage: head at entry zero, shift down on pop
	always_ff @(posedge i_mclk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (push && (CW'(i) == cnt_q - CW'(pop))) begin
				mem_q[i] <= i_wr_data;
			end else if (pop && (i < DEPTH - 1)) begin
				mem_q[i] <= mem_q[(i < DEPTH - 1) ? i + 1 : i];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// occupancy and flags, all registered
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_q      <= '0;
			o_rd_valid <= 1'b0;
			o_wr_ready <= 1'b1;
		end else begin
			cnt_q      <= cnt_d;
			o_rd_valid <= (cnt_d != '0);
			o_wr_ready <= (cnt_d != CW'(DEPTH));
		end
	end

endmodule // rba_fifo

// ### design/rba_block_cmd.sv
// rf block access command handler: single read, single write, multi read
// assumes a frame decoder on the same clock that strips request crc
// and a memory core that answers reads and runs programming cycles
//
// Summary of operation
// - Read single block 20h returns block data, security byte first if option set.
// - Failed single read replies error flag with 0Fh, 10h absent or 15h read-protected.
// - Busy mode: activity pin low from request start to end of response.
// - Write-in-progress mode: activity pin released for all read commands.
// - Write single block 21h programs 32-bit data into addressed block.
// - Protocol extension flag zero makes device answer an error code.
// - Write response sent only after programming; success is flags plus crc.
// - Failed write returns 0Fh, 10h, 12h or 13h.
// - Busy mode: pin low from write request start to end of response.
// - Write-in-progress mode: pin low from request end to response start; this design drives it only while in S_PROG.
// - Block count field is number of blocks minus one.
// - Multi read stays within one 32-block sector, else error.
// - Multi read sends 32 bits per block, each with optional security byte.
// - Security byte: lock b0, protection b2:1, password b4:3, b7:5 zero.
// - Failed multi read returns 0Fh, 10h or 15h.
// - Busy mode: pin low from multi read request start to response end.
//
// Strobed register access and the address map are this design's own decisions.
`include "rba_defines.svh"
`timescale 1ns/1ps

module rba_block_cmd #(
	parameter int NUM_BLOCKS = 2048,
	parameter int WIN_CYC    = `RBA_WIN_CYC,
	parameter int FIFO_DEPTH = 4
) (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	// request byte stream from frame decoder
	input  wire logic        i_rx_sof,
	input  wire logic        i_rx_valid,
	input  wire logic [7:0]  i_rx_byte,
	input  wire logic        i_rx_eof,
	input  wire logic        i_rx_crc_ok,
	// response byte stream to frame encoder
	output logic             o_tx_valid,
	output logic [7:0]       o_tx_byte,
	output logic             o_tx_last,
	input  wire logic        i_tx_ready,
	input  wire logic        i_tx_done,
	// memory core
	output logic             o_mem_rd,
	output logic             o_mem_wr,
	output logic [15:0]      o_mem_blk,
	output logic [31:0]      o_mem_wdata,
	input  wire logic        i_mem_ack,
	input  wire logic [31:0] i_mem_rdata,
	input  wire logic [7:0]  i_mem_sss,
	input  wire logic        i_mem_rd_prot,
	input  wire logic        i_mem_wr_lock,
	input  wire logic        i_mem_prog_done,
	input  wire logic        i_mem_prog_fail,
	// activity pin, open drain
	input  wire logic        i_act_mode_wip,
	output logic             o_rf_activity_out,
	output logic             o_rf_activity_oe
);

	localparam int WW = $clog2(WIN_CYC + 1);

	if (NUM_BLOCKS < 32 || NUM_BLOCKS > 65536 || WIN_CYC < 1) begin : g_bad_param
		$error("rba_block_cmd parameters out of range");
	end

	rba_pkg::rba_state_t st_q;
	logic [4:0]  rx_idx_q;
	logic [7:0]  flags_q;
	logic [7:0]  cmd_q;
	logic [55:0] arg_q;
	logic [47:0] out_q;
	logic [2:0]  nb_q;
	logic        crc_ph_q;
	logic        err_q;
	logic        first_q;
	logic [15:0] crc_q;
	logic [15:0] cur_q;
	logic [7:0]  left_q;
	logic [WW-1:0] rf_program_window_q;
	logic        pdone_q;
	logic        pfail_q;
	logic [8:0]  rds_q;
	logic        fifo_ready;
	logic        push;
	logic [4:0]  ai;
	logic [16:0] blk_end;
	logic        is_wr;
	logic        is_multi;
	logic        opt;
	logic        act_d;
	logic [7:0]  sss_m;

	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `RBA_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////
	// request field decode
	assign ai       = rx_idx_q - (flags_q[`RBA_FLG_ADDR] ? `RBA_ARG_BASE_UID : `RBA_ARG_BASE);
	assign is_wr    = (cmd_q == `RBA_CMD_WR_SINGLE);
	assign is_multi = (cmd_q == `RBA_CMD_RD_MULTI);
	assign opt      = flags_q[`RBA_FLG_OPT];
	assign blk_end  = {1'b0, arg_q[15:0]} + {9'h000, (is_multi ? arg_q[23:16] : 8'h00)};
	assign sss_m    = i_mem_sss & `RBA_SSS_MASK;
	assign push     = (st_q == rba_pkg::S_PUSH) && (nb_q != 3'h0) && fifo_ready;

	////////////////////////////////////////////////////////////////
	// request capture, flags and command then arguments
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_idx_q <= 5'h00;
			flags_q  <= 8'h00;
			cmd_q    <= 8'h00;
			arg_q    <= '0;
		end else if (st_q == rba_pkg::S_IDLE && i_rx_sof) begin
			rx_idx_q <= 5'h00;
			arg_q    <= '0;
		end else if (st_q == rba_pkg::S_RX && i_rx_valid) begin
			if (rx_idx_q != 5'h1F) begin
				rx_idx_q <= rx_idx_q + 5'h01;
			end
			if (rx_idx_q == 5'h00) begin
				flags_q <= i_rx_byte;
			end else if (rx_idx_q == 5'h01) begin
				cmd_q <= i_rx_byte;
			end else if (rx_idx_q >= (flags_q[`RBA_FLG_ADDR] ? `RBA_ARG_BASE_UID : `RBA_ARG_BASE)
				&& ai < 5'(`RBA_ARG_BYTES)) begin
				arg_q[ai*8 +: 8] <= i_rx_byte;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// command sequencer and response assembly
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_q     <= rba_pkg::S_IDLE;
			out_q    <= '0;
			nb_q     <= 3'h0;
			crc_ph_q <= 1'b0;
			err_q    <= 1'b0;
			first_q  <= 1'b0;
			cur_q    <= 16'h0000;
			left_q   <= 8'h00;
		end else begin
			case (st_q)
				rba_pkg::S_IDLE: begin
					if (i_rx_sof) begin
						st_q <= rba_pkg::S_RX;
					end
				end
				rba_pkg::S_RX: begin
					if (i_rx_eof) begin
						if (i_rx_crc_ok && (cmd_q == `RBA_CMD_RD_SINGLE || is_wr || is_multi)) begin
							st_q <= rba_pkg::S_CHECK;
						end else begin
							st_q <= rba_pkg::S_IDLE;
						end
					end
				end
				rba_pkg::S_CHECK: begin
					crc_ph_q <= 1'b0;
					first_q  <= 1'b1;
					cur_q    <= arg_q[15:0];
					left_q   <= is_multi ? arg_q[23:16] + 8'h01 : 8'h01;
					nb_q     <= 3'h2;
					err_q    <= 1'b1;
					st_q     <= rba_pkg::S_PUSH;
					if (!flags_q[`RBA_FLG_PEXT]) begin
						out_q <= {32'h0000_0000, `RBA_ERR_UNSPEC, `RBA_RSP_ERR};
					end else if (blk_end >= 17'(NUM_BLOCKS)) begin
						out_q <= {32'h0000_0000, `RBA_ERR_ABSENT, `RBA_RSP_ERR};
					end else if (is_multi && (arg_q[15:`RBA_SECT_BITS] != blk_end[15:`RBA_SECT_BITS])) begin
						out_q <= {32'h0000_0000, `RBA_ERR_UNSPEC, `RBA_RSP_ERR};
					end else begin
						err_q <= 1'b0;
						nb_q  <= 3'h0;
						st_q  <= rba_pkg::S_FETCH;
					end
				end
				rba_pkg::S_FETCH: begin
					st_q <= rba_pkg::S_WAIT_RD;
				end
				rba_pkg::S_WAIT_RD: begin
					if (i_mem_ack) begin
						first_q <= 1'b0;
						cur_q   <= cur_q + 16'h0001;
						left_q  <= left_q - 8'h01;
						st_q    <= rba_pkg::S_PUSH;
						if (is_wr) begin
							if (i_mem_wr_lock) begin
								err_q <= 1'b1;
								nb_q  <= 3'h2;
								out_q <= {32'h0000_0000, `RBA_ERR_LOCKED, `RBA_RSP_ERR};
							end else begin
								st_q <= rba_pkg::S_PROG;
							end
						end else if (first_q && i_mem_rd_prot) begin
							// one sector per request, so the first block speaks for all
							err_q <= 1'b1;
							nb_q  <= 3'h2;
							out_q <= {32'h0000_0000, `RBA_ERR_RD_PROT, `RBA_RSP_ERR};
						end else if (first_q) begin
							nb_q  <= opt ? 3'h6 : 3'h5;
							out_q <= opt ? {i_mem_rdata, sss_m, `RBA_RSP_OK} : {8'h00, i_mem_rdata, `RBA_RSP_OK};
						end else begin
							nb_q  <= opt ? 3'h5 : 3'h4;
							out_q <= opt ? {8'h00, i_mem_rdata, sss_m} : {16'h0000, i_mem_rdata};
						end
					end
				end
				rba_pkg::S_PROG: begin
					// answer only once programming ended and the window ran out
					if (pdone_q && rf_program_window_q == '0) begin
						st_q <= rba_pkg::S_PUSH;
						if (pfail_q) begin
							err_q <= 1'b1;
							nb_q  <= 3'h2;
							out_q <= {32'h0000_0000, `RBA_ERR_PROG, `RBA_RSP_ERR};
						end else begin
							nb_q  <= 3'h1;
							out_q <= {40'h00_0000_0000, `RBA_RSP_OK};
						end
					end
				end
				rba_pkg::S_PUSH: begin
					if (push) begin
						out_q <= out_q >> 8;
						nb_q  <= nb_q - 3'h1;
					end else if (nb_q == 3'h0) begin
						st_q <= rba_pkg::S_NEXT;
					end
				end
				rba_pkg::S_NEXT: begin
					if (crc_ph_q) begin
						st_q <= rba_pkg::S_DONE;
					end else if (!err_q && !is_wr && left_q != 8'h00) begin
						st_q <= rba_pkg::S_FETCH;
					end else begin
						crc_ph_q <= 1'b1;
						nb_q     <= 3'h2;
						out_q    <= {32'h0000_0000, ~crc_q};
						st_q     <= rba_pkg::S_PUSH;
					end
				end
				rba_pkg::S_DONE: begin
					if (i_tx_done) begin
						st_q <= rba_pkg::S_IDLE;
					end
				end
				default: begin
					st_q <= rba_pkg::S_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// response crc over every byte before the crc itself
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			crc_q <= `RBA_CRC_INIT;
		end else if (st_q == rba_pkg::S_CHECK) begin
			crc_q <= `RBA_CRC_INIT;
		end else if (push && !crc_ph_q) begin
			crc_q <= crc_upd(crc_q, out_q[7:0]);
		end
	end

	////////////////////////////////////////////////////////////////
	// memory strobes, registered
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_mem_rd    <= 1'b0;
			o_mem_wr    <= 1'b0;
			o_mem_blk   <= 16'h0000;
			o_mem_wdata <= 32'h0000_0000;
		end else begin
			o_mem_rd <= (st_q == rba_pkg::S_FETCH);
			o_mem_wr <= (st_q == rba_pkg::S_WAIT_RD) && i_mem_ack && is_wr && !i_mem_wr_lock;
			if (st_q == rba_pkg::S_FETCH) begin
				o_mem_blk   <= cur_q;
				o_mem_wdata <= arg_q[47:16];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// programming window timer and programming outcome
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rf_program_window_q <= '0;
			pdone_q             <= 1'b0;
			pfail_q             <= 1'b0;
		end else if (st_q == rba_pkg::S_CHECK) begin
			rf_program_window_q <= WW'(WIN_CYC);
			pdone_q             <= 1'b0;
			pfail_q             <= 1'b0;
		end else begin
			if (rf_program_window_q != '0) begin
				rf_program_window_q <= rf_program_window_q - WW'(1);
			end
			if (i_mem_prog_done && st_q == rba_pkg::S_PROG) begin
				pdone_q <= 1'b1;
				pfail_q <= i_mem_prog_fail;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// activity pin: busy covers the whole exchange, wip only programming
	assign act_d = i_act_mode_wip ? (st_q == rba_pkg::S_PROG)
		: (st_q != rba_pkg::S_IDLE);

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rf_activity_out <= 1'b0;
			o_rf_activity_oe  <= 1'b0;
		end else begin
			o_rf_activity_out <= 1'b0;
			o_rf_activity_oe  <= act_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// response buffer toward the frame encoder
	rba_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_mclk     (i_mclk),
		.i_reset_n  (i_reset_n),
		.i_wr_valid ((st_q == rba_pkg::S_PUSH) && (nb_q != 3'h0)),
		.i_wr_data  ({crc_ph_q && nb_q == 3'h1, out_q[7:0]}),
		.o_wr_ready (fifo_ready),
		.o_rd_valid (o_tx_valid),
		.o_rd_data  ({o_tx_last, o_tx_byte}),
		.i_rd_ready (i_tx_ready)
	);

	////////////////////////////////////////////////////////////////
	// checks
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rds_q <= 9'h000;
		end else if (st_q == rba_pkg::S_CHECK) begin
			rds_q <= 9'h000;
		end else if (st_q == rba_pkg::S_WAIT_RD && i_mem_ack) begin
			rds_q <= rds_q + 9'h001;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	sequence s_prog_end;
		st_q == rba_pkg::S_PROG ##1 st_q != rba_pkg::S_PROG;
	endsequence

	sequence s_read_ok;
		st_q == rba_pkg::S_NEXT && !crc_ph_q && !err_q && !is_wr && left_q == 8'h00;
	endsequence

	busy_from_sof_a: assert property (
		st_q == rba_pkg::S_IDLE && i_rx_sof && !i_act_mode_wip ##1 !i_act_mode_wip |=> o_rf_activity_oe)
		else $error("activity pin not driven after request start");
	wip_read_hiz_a: assert property (
		i_act_mode_wip && $stable(i_act_mode_wip) && !is_wr && st_q != rba_pkg::S_IDLE |=> !o_rf_activity_oe)
		else $error("activity pin driven during a read");
	wip_prog_low_a: assert property (
		i_act_mode_wip [*2] ##0 st_q == rba_pkg::S_PROG ##1 st_q == rba_pkg::S_PROG |-> o_rf_activity_oe)
		else $error("activity pin released during programming");
	pext_error_a: assert property (
		st_q == rba_pkg::S_CHECK && !flags_q[`RBA_FLG_PEXT]
		|=> st_q == rba_pkg::S_PUSH && out_q[15:0] == {`RBA_ERR_UNSPEC, `RBA_RSP_ERR})
		else $error("missing extension flag not answered with error");
	sector_cross_a: assert property (
		st_q == rba_pkg::S_CHECK && flags_q[`RBA_FLG_PEXT] && is_multi
		&& arg_q[15:5] != blk_end[15:5] |=> err_q && o_mem_rd == 1'b0)
		else $error("sector crossing read not refused");
	prog_before_rsp_a: assert property (
		s_prog_end |-> rf_program_window_q == '0 && pdone_q)
		else $error("write answered before programming ended");
	block_count_a: assert property (
		s_read_ok |-> rds_q == (is_multi ? {1'b0, arg_q[23:16]} + 9'h001 : 9'h001))
		else $error("wrong number of blocks read");
	crc_last_a: assert property (
		push && crc_ph_q && nb_q == 3'h1 |=> ##[1:300] st_q == rba_pkg::S_NEXT)
		else $error("response crc not closing the frame");
	absent_err_a: assert property (
		st_q == rba_pkg::S_CHECK && flags_q[`RBA_FLG_PEXT] && blk_end >= 17'(NUM_BLOCKS)
		|=> out_q[15:8] == `RBA_ERR_ABSENT)
		else $error("absent block not reported");

endmodule // rba_block_cmd

// ### bench/rba_reader_model.sv
// reader-side model: sends request frames, takes response bytes
// assumes one clock shared with the command handler
`timescale 1ns/1ps

module rba_reader_model (
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_reset_n,
	// request stream to handler
	output logic            o_rx_sof,
	output logic            o_rx_valid,
	output logic [7:0]      o_rx_byte,
	output logic            o_rx_eof,
	output logic            o_rx_crc_ok,
	// response stream from handler
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_byte,
	input  wire logic       i_tx_last,
	output logic            o_tx_ready,
	output logic            o_tx_done,
	// stall control
	input  wire logic       i_slow
);
	logic [7:0] rsp[$];
	int         n_done = 0;
	logic       ph_q;
	logic [3:0] done_sr;

	// idle request lines at time zero
	initial begin
		{o_rx_sof, o_rx_valid, o_rx_eof, o_rx_crc_ok} = 4'h0;
		o_rx_byte = 8'h00;
	end

	// one request frame; crc bytes are checked upstream, only its verdict is sent
	task automatic send(input logic [7:0] req[$], input logic crc_ok);
		@(posedge i_mclk) o_rx_sof <= 1'b1;
		@(posedge i_mclk) o_rx_sof <= 1'b0;
		foreach (req[i]) begin
			o_rx_valid <= 1'b1;
			o_rx_byte  <= req[i];
			@(posedge i_mclk);
		end
		o_rx_valid  <= 1'b0;
		o_rx_byte   <= ~o_rx_byte; // released byte lane never shows a stale value
		o_rx_eof    <= 1'b1;
		o_rx_crc_ok <= crc_ok;
		@(posedge i_mclk) o_rx_eof <= 1'b0;
		o_rx_crc_ok <= ~crc_ok;
	endtask

	// take response bytes, stalling every other cycle when slow; no new frame until done
	// end of frame follows the last byte a few cycles later, as a serialising encoder's would
	always @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ph_q       <= 1'b0;
			o_tx_ready <= 1'b0;
			o_tx_done  <= 1'b0;
			done_sr    <= 4'h0;
		end else begin
			ph_q       <= ~ph_q;
			o_tx_ready <= !i_slow || ph_q;
			done_sr    <= {done_sr[2:0], i_tx_valid && o_tx_ready && i_tx_last};
			o_tx_done  <= done_sr[3];
			if (i_tx_valid && o_tx_ready) rsp.push_back(i_tx_byte);
			if (o_tx_done) n_done <= n_done + 1;
		end
	end
endmodule // rba_reader_model

// ### bench/tb_rba_block_cmd.sv
// bench for the block access command handler
// assumes the design files and the reader model are compiled first
`timescale 1ns/1ps

module tb_rba_block_cmd;
	typedef logic [7:0] rba_bytes_t[$];
	typedef struct packed {
		logic [7:0]  fl;
		logic [7:0]  cmd;
		logic [15:0] blk;
		logic [31:0] arg;
		logic [7:0]  err;
		logic        wip;
	} rba_row_t;
	localparam int WIN = 20;
	logic        i_mclk, i_reset_n, i_act_mode_wip, i_slow, rx_sof, rx_valid, rx_eof, rx_crc_ok;
	logic        tx_ready, tx_done, o_tx_valid, o_tx_last, o_mem_rd, o_mem_wr, i_mem_ack, act_seen, tx_seen;
	logic        i_mem_rd_prot, i_mem_wr_lock, i_mem_prog_done, i_mem_prog_fail, o_rf_activity_out, o_rf_activity_oe;
	logic [7:0]  rx_byte, o_tx_byte, i_mem_sss;
	logic [15:0] o_mem_blk;
	logic [31:0] o_mem_wdata, i_mem_rdata, wr_data;
	logic [1:0]  ack_sr;
	logic [3:0]  prog_cnt;
	int          n_fail, checked, cyc, eof_cyc, tx_cyc;
	// fl cmd blk arg err wip
	rba_row_t rows[17] = '{
		'{8'h08, 8'h20, 16'h0005, 32'h0, 8'h00, 1'b0}, '{8'h48, 8'h20, 16'h0007, 32'h0, 8'h00, 1'b1},
		'{8'h28, 8'h20, 16'h0800, 32'h0, 8'h10, 1'b0}, '{8'h08, 8'h20, 16'h0040, 32'h0, 8'h15, 1'b1},
		'{8'h00, 8'h20, 16'h0005, 32'h0, 8'h0F, 1'b0}, '{8'h08, 8'h21, 16'h0003, 32'h1234_5678, 8'h00, 1'b0},
		'{8'h68, 8'h21, 16'h0004, 32'hCAFE_0001, 8'h00, 1'b1}, '{8'h08, 8'h21, 16'h0080, 32'h1, 8'h12, 1'b0},
		'{8'h08, 8'h21, 16'h0009, 32'hDEAD_BEEF, 8'h13, 1'b1}, '{8'h08, 8'h21, 16'h0800, 32'h1, 8'h10, 1'b0},
		'{8'h00, 8'h21, 16'h0003, 32'h1, 8'h0F, 1'b0}, '{8'h48, 8'h23, 16'h0020, 32'h3, 8'h00, 1'b0},
		'{8'h08, 8'h23, 16'h07FF, 32'h0, 8'h00, 1'b1}, '{8'h08, 8'h23, 16'h001E, 32'h2, 8'h0F, 1'b0},
		'{8'h08, 8'h23, 16'h0040, 32'h1, 8'h15, 1'b0}, '{8'h08, 8'h23, 16'h0800, 32'h0, 8'h10, 1'b0},
		'{8'h00, 8'h23, 16'h0020, 32'h1, 8'h0F, 1'b1}};

	rba_block_cmd #(.WIN_CYC(WIN)) rba_block_cmd_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_rx_sof(rx_sof), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .i_rx_eof(rx_eof), .i_rx_crc_ok(rx_crc_ok),
		.o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .o_tx_last(o_tx_last), .i_tx_ready(tx_ready),
		.i_tx_done(tx_done), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_blk(o_mem_blk),
		.o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .i_mem_sss(i_mem_sss),
		.i_mem_rd_prot(i_mem_rd_prot), .i_mem_wr_lock(i_mem_wr_lock), .i_mem_prog_done(i_mem_prog_done),
		.i_mem_prog_fail(i_mem_prog_fail), .i_act_mode_wip(i_act_mode_wip),
		.o_rf_activity_out(o_rf_activity_out), .o_rf_activity_oe(o_rf_activity_oe));
	rba_reader_model reader_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .o_rx_sof(rx_sof), .o_rx_valid(rx_valid),
		.o_rx_byte(rx_byte), .o_rx_eof(rx_eof), .o_rx_crc_ok(rx_crc_ok), .i_tx_valid(o_tx_valid),
		.i_tx_byte(o_tx_byte), .i_tx_last(o_tx_last), .o_tx_ready(tx_ready), .o_tx_done(tx_done), .i_slow(i_slow));

	// memory core: data tracks block number, answer two cycles on, programming ten cycles
	always @(posedge i_mclk) begin
		ack_sr          <= {ack_sr[0], o_mem_rd};
		i_mem_ack       <= ack_sr[0];
		i_mem_rdata     <= {~o_mem_blk, o_mem_blk};
		i_mem_sss       <= {3'b111, o_mem_blk[4:0]};
		i_mem_rd_prot   <= (o_mem_blk == 16'h0040);
		i_mem_wr_lock   <= (o_mem_blk == 16'h0080);
		i_mem_prog_fail <= (o_mem_wdata == 32'hDEAD_BEEF);
		i_mem_prog_done <= (prog_cnt == 4'h1);
		prog_cnt        <= o_mem_wr ? 4'hA : prog_cnt - {3'h0, prog_cnt != 4'h0};
		if (o_mem_wr) wr_data <= o_mem_wdata;
	end

	// activity pin and frame timing monitor
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (o_rf_activity_oe) act_seen <= 1'b1;
		if (rx_eof) eof_cyc <= cyc;
		if (o_tx_valid && !tx_seen) tx_cyc <= cyc;
		if (o_tx_valid) tx_seen <= 1'b1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// expected response bytes with trailing crc
	function automatic rba_bytes_t expect_rsp(input rba_row_t r);
		rba_bytes_t  q;
		logic [15:0] c;
		logic [15:0] b;
		int          n;
		q = {(r.err != 8'h00) ? 8'h01 : 8'h00};
		n = (r.cmd == 8'h23) ? r.arg[7:0] + 1 : (r.cmd == 8'h20);
		if (r.err != 8'h00) q.push_back(r.err);
		else for (int i = 0; i < n; i++) begin
			b = r.blk + i[15:0];
			if (r.fl[6]) q.push_back({3'b000, b[4:0]});
			for (int k = 0; k < 4; k++) q.push_back(k[1] ? ~b[8*k[0]+:8] : b[8*k[0]+:8]);
		end
		c = 16'hFFFF;
		foreach (q[j]) begin
			c ^= {8'h00, q[j]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		end
		c = ~c;
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		return q;
	endfunction

	// one request and its response, pin behaviour and write timing
	task automatic run(input rba_row_t r, input logic good);
		logic [7:0] req[$];
		rba_bytes_t exp_q;
		int         n0;
		logic       prog;
		req = {r.fl, r.cmd};
		if (r.fl[5]) for (int k = 0; k < 8; k++) req.push_back(8'hA0 + k[7:0]);
		req.push_back(r.blk[7:0]);
		req.push_back(r.blk[15:8]);
		if (r.cmd == 8'h21) for (int k = 0; k < 32; k += 8) req.push_back(r.arg[k+:8]);
		if (r.cmd == 8'h23) req.push_back(r.arg[7:0]);
		exp_q = expect_rsp(r);
		prog = (r.cmd == 8'h21) && (r.err == 8'h00 || r.err == 8'h13);
		i_act_mode_wip <= r.wip;
		act_seen <= 1'b0;
		tx_seen <= 1'b0;
		reader_i.rsp.delete();
		n0 = reader_i.n_done;
		reader_i.send(req, good);
		if (!good) begin
			repeat (60) @(posedge i_mclk);
			chk({31'h0, tx_seen}, 32'h0);
			return;
		end
		for (int k = 0; k < 3000 && reader_i.n_done == n0; k++) @(posedge i_mclk);
		chk({31'h0, reader_i.n_done != n0}, 32'h1);
		repeat (2) @(posedge i_mclk);
		chk(32'(reader_i.rsp.size()), 32'(exp_q.size()));
		foreach (exp_q[i]) chk({24'h0, reader_i.rsp[i]}, {24'h0, exp_q[i]});
		chk({31'h0, o_rf_activity_oe}, 32'h0);
		chk({31'h0, o_rf_activity_out}, 32'h0);
		if (!r.wip) chk({31'h0, act_seen}, 32'h1);
		else chk({31'h0, act_seen}, {31'h0, prog});
		if (prog) chk(wr_data, r.arg);
		if (prog) chk({31'h0, tx_cyc - eof_cyc >= WIN}, 32'h1);
	endtask

	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end

	// watchdog: all tests need well under 20000 cycles
	initial begin
		#(20 * 30000);
		n_fail++;
		test_done();
	end

	initial begin
		{i_reset_n, i_act_mode_wip, i_slow, i_mem_ack, i_mem_rd_prot, i_mem_wr_lock} = 6'h0;
		{i_mem_prog_done, i_mem_prog_fail, act_seen, tx_seen} = 4'h0;
		{ack_sr, prog_cnt, i_mem_sss, i_mem_rdata, wr_data} = 0;
		{n_fail, checked, cyc, eof_cyc, tx_cyc} = 0;
		repeat (2) @(posedge i_mclk);
		chk({o_tx_valid, o_tx_last, o_mem_rd, o_mem_wr, o_rf_activity_oe, o_mem_blk}, 32'h0);
		i_reset_n <= 1'b1;
		// table of ordinary cases
		foreach (rows[t]) begin
			run(rows[t], 1'b1);
			$display("test %0d ended", t);
		end
		// full 32-block sector with the encoder stalling
		i_slow <= 1'b1;
		run('{8'h48, 8'h23, 16'h0000, 32'h1F, 8'h00, 1'b0}, 1'b1);
		i_slow <= 1'b0;
		$display("test stall ended");
		// bad request crc: no answer
		run(rows[5], 1'b0);
		$display("test bad crc ended");
		// reset in mid response, then recovery
		fork
			run(rows[11], 1'b1);
		join_none
		for (int k = 0; k < 500 && o_tx_valid !== 1'b1; k++) @(posedge i_mclk);
		disable fork;
		i_reset_n <= 1'b0;
		@(posedge i_mclk);
		@(negedge i_mclk);
		chk({o_tx_valid, o_mem_rd, o_mem_wr, o_rf_activity_oe}, 32'h0);
		@(posedge i_mclk);
		i_reset_n <= 1'b1;
		run(rows[6], 1'b1);
		$display("test reset ended");
		test_done();
	end
endmodule // tb_rba_block_cmd
